// ### wdt_defs.svh
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ----------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------
`define IDX_RESET_STATUS  10'h285
`define IDX_IRQ_CONFIG    10'h286
`define IDX_CONTROL       10'h28c
`define IDX_EVENT_STATUS  10'h2a0
`define IDX_EVENT_MASK    10'h2a1
`define ADDR_RESET_STATUS (12'(`IDX_RESET_STATUS * 4))
`define ADDR_IRQ_CONFIG   (12'(`IDX_IRQ_CONFIG * 4))
`define ADDR_CONTROL      (12'(`IDX_CONTROL * 4))
`define ADDR_EVENT_STATUS (12'(`IDX_EVENT_STATUS * 4))
`define ADDR_EVENT_MASK   (12'(`IDX_EVENT_MASK * 4))

// ----------------------------------------------------------------------
// watchdog_control fields
// ----------------------------------------------------------------------
`define CTRL_EXPIRED_BIT  7
`define CTRL_MODE_HI      6
`define CTRL_MODE_LO      5
`define CTRL_ENABLE_BIT   4
`define CTRL_TMO_HI       3
`define CTRL_TMO_LO       0
`define CTRL_TMO_RESET    4'h0
`define CTRL_MODE_RESET   2'h0

// ----------------------------------------------------------------------
// board_irq_config and reset status fields
// ----------------------------------------------------------------------
`define ROUTE_HI          1
`define ROUTE_LO          0
`define ROUTE_RESET       2'h0
`define ROUTE_LINE5       2'h1
`define CAUSE_BIT         0

// ----------------------------------------------------------------------
// event status bits
// ----------------------------------------------------------------------
`define EVT_WIDTH         3
`define EVT_STAGE_IRQ     0
`define EVT_EXPIRED       1
`define EVT_HARD_RESET    2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_PS     25000
`define BASE_PERIOD_PS    64'd125000000000
`define HARD_RESET_PS     1000000
`define HARD_RESET_CYCLES (8'(`HARD_RESET_PS / `CLK_PERIOD_PS))
`define COUNT_WIDTH       16
`define COUNT_ONE         16'h0001

`endif

// ### wdt_pkg.sv
package wdt_pkg;
  // mode field encoding follows declaration order 00..11
  typedef enum logic [1:0] {MODE_TIMER, MODE_RESET, MODE_IRQ, MODE_DUAL} wd_mode_t;
  // countdown sequencer
  typedef enum logic [1:0] {WD_OFF, WD_RUN, WD_SECOND, WD_HALTED} wd_state_t;
endpackage

// ### wd_tick_gen.sv
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wd_tick_gen #(
  parameter int TICK_CYCLES = 5000000
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // control
  input  wire logic restart,
  // base tick
  output logic      tick
);
  logic [31:0] cycleCount;

  // ----------------------------------------------------------------------
  // base period divider
  // ----------------------------------------------------------------------
  // restart realigns the phase so a period starts at each load
  always_ff @(posedge clk_sys) begin
    if (rst || restart) begin
      cycleCount <= 32'h0;
      tick       <= 1'b0;
    end else if (cycleCount == 32'(TICK_CYCLES - 1)) begin
      cycleCount <= 32'h0;
      tick       <= 1'b1;
    end else begin
      cycleCount <= cycleCount + 32'h1;
      tick       <= 1'b0;
    end
  end
endmodule // wd_tick_gen

// ### wd_event_status.sv
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wd_event_status (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // events and software access
  input  wire logic [`EVT_WIDTH-1:0] events,
  input  wire logic [`EVT_WIDTH-1:0] clearBits,
  input  wire logic                  maskWrite,
  input  wire logic [`EVT_WIDTH-1:0] maskData,
  // state
  output logic      [`EVT_WIDTH-1:0] status,
  output logic      [`EVT_WIDTH-1:0] mask,
  output logic                       pending
);
  // ----------------------------------------------------------------------
  // sticky bits, write one to clear, set wins
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `EVT_WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          status[i] <= 1'b0;
        end else if (events[i]) begin
          status[i] <= 1'b1;
        end else if (clearBits[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // mask register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask <= '0;
    end else if (maskWrite) begin
      mask <= maskData;
    end
  end

  assign pending = |(status & mask);
endmodule // wd_event_status

// ### board_watchdog_timer.sv
// Operation
// - four-bit select, 0.125 s times two^n
// - disabled after power-on until software enables
// - enabled locks enable and mode until power-cycle
// - writing one to enable bit reloads countdown
// - enable bit reads one, zero writes ignored
// - timeout sets expired flag in every mode
// - expired flag clears only on written one or power-on reset
// - mode: timer, reset, interrupt, dual-stage
// - timer-only mode just sets expired flag and expired event bit
// - expired flag survives forced hard reset
// - reset mode forces hard reset on timeout
// - interrupt mode raises interrupt on timeout
// - routing field gates interrupt to host
// - dual first timeout interrupts and reloads
// - dual second timeout resets, retrigger resumes
// - routing field: 00 off, 01 line five
// - reset-cause flag set on forced reset, w1c
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "wdt_defs.svh"
module board_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int TICK_CYCLES = int'(`BASE_PERIOD_PS / `CLK_PERIOD_PS)
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // system
  output logic             irqLine5,
  output logic             hardReset
);
  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  // register and sequencer state
  wd_mode_t                mode;
  wd_state_t               state;
  logic                    wdEnabled;
  logic [3:0]              timeoutSelect;
  logic                    expiredFlag;
  logic                    resetCauseFlag;
  logic [1:0]              irqRoute;
  logic [`COUNT_WIDTH-1:0] remaining;
  logic [7:0]              hardResetCount;
  logic                    tick;
  logic [`EVT_WIDTH-1:0]   evtStatus;
  logic [`EVT_WIDTH-1:0]   evtMask;
  logic                    evtPending;

  // bus decode and sequencer strobes
  logic                    accessNow;
  logic                    commit;
  logic                    writeCommit;
  logic                    addrKnown;
  logic                    ctrlWrite;
  logic                    retrigger;
  logic                    enableNow;
  logic                    reload;
  logic [3:0]              loadSelect;
  logic [`COUNT_WIDTH-1:0] loadCount;
  logic                    lastTick;
  logic                    timeout;
  logic                    fireStage;
  logic                    fireReset;
  logic                    autoReload;
  logic [`EVT_WIDTH-1:0]   evtClear;
  logic [`EVT_WIDTH-1:0]   evtSet;
  logic [7:0]              ctrlRead;
  logic [31:0]             next_prdata;

  // ----------------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------------
  // one wait state: data is prepared, then the access completes
  assign accessNow   = psel & penable & ~pready;
  assign commit      = psel & penable & pready;
  assign writeCommit = commit & pwrite;

  // any other address answers with an error
  always_comb begin
    addrKnown = (paddr == `ADDR_CONTROL) || (paddr == `ADDR_IRQ_CONFIG) ||
                (paddr == `ADDR_RESET_STATUS) || (paddr == `ADDR_EVENT_STATUS) ||
                (paddr == `ADDR_EVENT_MASK);
  end

  // ready and error answer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= accessNow;
      pslverr <= accessNow & ~addrKnown;
    end
  end

  // ----------------------------------------------------------------------
  // control register decode
  // ----------------------------------------------------------------------
  // enabling write, retrigger write and the reload they share
  assign ctrlWrite  = writeCommit && (paddr == `ADDR_CONTROL);
  assign enableNow  = ctrlWrite && !wdEnabled && pwdata[`CTRL_ENABLE_BIT];
  assign retrigger  = ctrlWrite && wdEnabled && pwdata[`CTRL_ENABLE_BIT];
  assign reload     = enableNow || retrigger;
  // a write carrying a new period uses it for its own reload
  assign loadSelect = ctrlWrite ? pwdata[`CTRL_TMO_HI:`CTRL_TMO_LO] : timeoutSelect;
  assign loadCount  = `COUNT_ONE << loadSelect;

  // enable and mode, locked once running
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wdEnabled <= 1'b0;
      mode      <= wd_mode_t'(`CTRL_MODE_RESET);
    end else if (ctrlWrite && !wdEnabled) begin
      mode      <= wd_mode_t'(pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
      wdEnabled <= pwdata[`CTRL_ENABLE_BIT];
    end
    // once set, only power-on reset clears it
  end

  // timeout select stays writable at any time
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timeoutSelect <= `CTRL_TMO_RESET;
    end else if (ctrlWrite) begin
      timeoutSelect <= pwdata[`CTRL_TMO_HI:`CTRL_TMO_LO];
    end
  end

  // ----------------------------------------------------------------------
  // base tick
  // ----------------------------------------------------------------------
  wd_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .restart (reload || autoReload),
    .tick    (tick)
  );

  // ----------------------------------------------------------------------
  // countdown sequencer
  // ----------------------------------------------------------------------
  // expiry on the last tick, unless a retrigger lands in the same cycle
  assign lastTick  = tick && (remaining == `COUNT_ONE);
  assign timeout   = lastTick && !retrigger &&
                     (state == WD_RUN || state == WD_SECOND);
  assign fireStage = timeout && state == WD_RUN &&
                     (mode == MODE_IRQ || mode == MODE_DUAL);
  assign fireReset = timeout && ((state == WD_RUN && mode == MODE_RESET) ||
                                 state == WD_SECOND);
  // first dual-stage expiry restarts the period on its own
  assign autoReload = timeout && state == WD_RUN && mode == MODE_DUAL;

  // countdown state, one step per base tick
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state     <= WD_OFF;
      remaining <= '0;
    end else begin
      case (state)
        WD_OFF: begin
          // nothing counts until the enabling write
          if (enableNow) begin
            state     <= WD_RUN;
            remaining <= loadCount;
          end
        end
        WD_RUN: begin
          if (retrigger) begin
            remaining <= loadCount;
          end else if (timeout) begin
            if (mode == MODE_DUAL) begin
              state     <= WD_SECOND;
              remaining <= loadCount;
            end else begin
              // other modes halt after a single expiry
              state     <= WD_HALTED;
            end
          end else if (tick) begin
            remaining <= remaining - `COUNT_ONE;
          end
        end
        WD_SECOND: begin
          // a retrigger between the stages resumes normal counting
          if (retrigger) begin
            state     <= WD_RUN;
            remaining <= loadCount;
          end else if (timeout) begin
            state     <= WD_HALTED;
          end else if (tick) begin
            remaining <= remaining - `COUNT_ONE;
          end
        end
        WD_HALTED: begin
          // counting stops until software retriggers
          if (retrigger) begin
            state     <= WD_RUN;
            remaining <= loadCount;
          end
        end
        default: begin
          state     <= WD_OFF;
          remaining <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // expired flag
  // ----------------------------------------------------------------------
  // power-on reset or a written one clears it, never the forced hard reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      expiredFlag <= 1'b0;
    end else if (timeout) begin
      expiredFlag <= 1'b1;
    end else if (ctrlWrite && pwdata[`CTRL_EXPIRED_BIT]) begin
      expiredFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // hard reset pulse and reset cause
  // ----------------------------------------------------------------------
  // fixed-width pulse, the forced reset does not touch this block
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hardResetCount <= 8'h0;
      hardReset      <= 1'b0;
    end else if (fireReset) begin
      hardResetCount <= `HARD_RESET_CYCLES - 8'h1;
      hardReset      <= 1'b1;
    end else if (hardResetCount != 8'h0) begin
      hardResetCount <= hardResetCount - 8'h1;
      hardReset      <= 1'b1;
    end else begin
      hardReset      <= 1'b0;
    end
  end

  // cause flag, set wins over a clearing write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resetCauseFlag <= 1'b0;
    end else if (fireReset) begin
      resetCauseFlag <= 1'b1;
    end else if (writeCommit && paddr == `ADDR_RESET_STATUS && pwdata[`CAUSE_BIT]) begin
      resetCauseFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt routing
  // ----------------------------------------------------------------------
  // routing field, reserved codes stored as written
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqRoute <= `ROUTE_RESET;
    end else if (writeCommit && paddr == `ADDR_IRQ_CONFIG) begin
      irqRoute <= pwdata[`ROUTE_HI:`ROUTE_LO];
    end
  end

  // event sources and software clears
  always_comb begin
    evtSet                  = '0;
    evtSet[`EVT_STAGE_IRQ]  = fireStage;
    evtSet[`EVT_EXPIRED]    = timeout;
    evtSet[`EVT_HARD_RESET] = fireReset;
    evtClear = (writeCommit && paddr == `ADDR_EVENT_STATUS) ?
               pwdata[`EVT_WIDTH-1:0] : '0;
  end

  // sticky event bits and their mask
  wd_event_status u_events (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .events    (evtSet),
    .clearBits (evtClear),
    .maskWrite (writeCommit && paddr == `ADDR_EVENT_MASK),
    .maskData  (pwdata[`EVT_WIDTH-1:0]),
    .status    (evtStatus),
    .mask      (evtMask),
    .pending   (evtPending)
  );

  // only code 01 drives line five, reserved codes act as off
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqLine5 <= 1'b0;
    end else begin
      irqLine5 <= evtPending && (irqRoute == `ROUTE_LINE5);
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  // read mux, unmapped addresses read zero
  always_comb begin
    ctrlRead = '0;
    ctrlRead[`CTRL_EXPIRED_BIT]           = expiredFlag;
    ctrlRead[`CTRL_MODE_HI:`CTRL_MODE_LO] = mode;
    ctrlRead[`CTRL_ENABLE_BIT]            = wdEnabled;
    ctrlRead[`CTRL_TMO_HI:`CTRL_TMO_LO]   = timeoutSelect;
    next_prdata = '0;
    if (paddr == `ADDR_CONTROL) begin
      next_prdata[7:0] = ctrlRead;
    end else if (paddr == `ADDR_IRQ_CONFIG) begin
      next_prdata[`ROUTE_HI:`ROUTE_LO] = irqRoute;
    end else if (paddr == `ADDR_RESET_STATUS) begin
      next_prdata[`CAUSE_BIT] = resetCauseFlag;
    end else if (paddr == `ADDR_EVENT_STATUS) begin
      next_prdata[`EVT_WIDTH-1:0] = evtStatus;
    end else if (paddr == `ADDR_EVENT_MASK) begin
      next_prdata[`EVT_WIDTH-1:0] = evtMask;
    end
  end

  // captured in the wait cycle, held through completion
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= '0;
    end else if (accessNow && !pwrite) begin
      prdata <= next_prdata;
    end
  end
endmodule // board_watchdog_timer

// ### board_watchdog_timer_assertions.sv
`timescale 1ns/1ps
`include "wdt_defs.svh"
module board_watchdog_timer_assertions (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // system
  input wire logic        irqLine5,
  input wire logic        hardReset
);
  logic [7:0] hrLen;
  logic       enSeen;
  wire        ctrlRd = pready && !pwrite && (paddr == `ADDR_CONTROL);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // length of the running hard reset pulse
  always_ff @(posedge clk_sys) begin
    if (rst || !hardReset) hrLen <= 8'h00;
    else hrLen <= hrLen + 8'h01;
  end

  // enable seen set on a control read
  always_ff @(posedge clk_sys) begin
    if (rst) enSeen <= 1'b0;
    else if (ctrlRd && prdata[`CTRL_ENABLE_BIT]) enSeen <= 1'b1;
  end

  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_ready_after_access; psel && penable && !pready |=> pready; endproperty
  a_ready_after_access: assert property (p_ready_after_access) else $error("pready late");
  property p_ready_needs_access; pready |-> psel && penable; endproperty
  a_ready_needs_access: assert property (p_ready_needs_access) else $error("pready w/o access");
  property p_err_with_ready; pslverr |-> pready; endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
  property p_err_ctrl; pready && paddr == `ADDR_CONTROL |-> !pslverr; endproperty
  a_err_ctrl: assert property (p_err_ctrl) else $error("error on control access");
  property p_unmapped_zero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_ctrl_upper; ctrlRd |-> prdata[31:8] == 24'h0; endproperty
  a_ctrl_upper: assert property (p_ctrl_upper) else $error("control upper bits set");
  property p_enable_sticky; ctrlRd && enSeen |-> prdata[`CTRL_ENABLE_BIT]; endproperty
  a_enable_sticky: assert property (p_enable_sticky) else $error("enable bit dropped");
  property p_reset_width; $fell(hardReset) |-> hrLen == `HARD_RESET_CYCLES; endproperty
  a_reset_width: assert property (p_reset_width) else $error("hard reset width wrong");
  property p_route_off; pready && pwrite && paddr == `ADDR_IRQ_CONFIG &&
    pwdata[`ROUTE_HI:`ROUTE_LO] != `ROUTE_LINE5 |=> ##1 !irqLine5; endproperty
  a_route_off: assert property (p_route_off) else $error("interrupt with route off");
endmodule // board_watchdog_timer_assertions

bind board_watchdog_timer board_watchdog_timer_assertions i_chk (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irqLine5(irqLine5), .hardReset(hardReset));

// ### tb_board_watchdog_timer.sv
`timescale 1ns/1ps
`include "wdt_defs.svh"
module tb_board_watchdog_timer import wdt_pkg::*;;
  localparam int TICK = 4;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic err;} row_t;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, irqLine5, hardReset, e, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int          bad_count, checks, cyc, hrCnt, t0;
  row_t        rows [13];

  board_watchdog_timer #(.TICK_CYCLES(TICK)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irqLine5(irqLine5), .hardReset(hardReset));

  // ----------------------------------------------------------------------
  // clock, counters and tasks
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // cycle and hard reset counts
  always @(posedge clk_sys) begin
    cyc++;
    if (hardReset === 1'b1) hrCnt++;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin bad_count++; wrap_up; end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [11:0] a); apb(1'b0, a, 32'h0); endtask
  task wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask

  task power_on;
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
  endtask

  // which 0 waits for the interrupt, 1 for the hard reset
  task wait_out(input int which, input int lim);
    int n;
    n = 0;
    ok = 1'b0;
    while (!ok && n < lim) begin
      @(posedge clk_sys);
      n++;
      ok = (which == 0) ? (irqLine5 === 1'b1) : (hardReset === 1'b1);
    end
    if (!ok) begin bad_count++; wrap_up; end
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    wrap_up;
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int n;
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    bad_count = 0; checks = 0; cyc = 0; hrCnt = 0;
    rows = '{'{0, `ADDR_CONTROL, 0, 0, 0}, '{0, `ADDR_IRQ_CONFIG, 0, 0, 0},
             '{0, `ADDR_RESET_STATUS, 0, 0, 0}, '{0, `ADDR_EVENT_STATUS, 0, 0, 0},
             '{0, `ADDR_EVENT_MASK, 0, 0, 0}, '{0, 12'h000, 0, 0, 1}, '{1, 12'hffc, 'hff, 0, 1},
             '{1, `ADDR_CONTROL, 'h65, 'h65, 0}, '{1, `ADDR_CONTROL, 0, 0, 0},
             '{1, `ADDR_IRQ_CONFIG, 'hff, 3, 0}, '{1, `ADDR_IRQ_CONFIG, 0, 0, 0},
             '{1, `ADDR_EVENT_MASK, 7, 7, 0}, '{1, `ADDR_EVENT_MASK, 0, 0, 0}};
    power_on;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d);
        check(e, rows[i].err);
      end
      rd(rows[i].a);
      check(r, rows[i].q);
      check(e, rows[i].err);
    end
    repeat (300) @(posedge clk_sys);
    rd(`ADDR_CONTROL);
    check(r, 32'h0);
    check(hrCnt, 0);
    // timer mode, periods 0 to 3, each timed from its reload
    wr(`ADDR_CONTROL, 32'h10);
    for (int s = 0; s < 4; s++) begin
      wr(`ADDR_CONTROL, 32'h90 | s);
      t0 = cyc;
      n = 0;
      do begin rd(`ADDR_CONTROL); n++; end while (r[7] !== 1'b1 && n < 30);
      if (n >= 30) begin bad_count++; wrap_up; end
      check((cyc - t0 >= (TICK << s)) && (cyc - t0 <= (TICK << s) + 8), 1);
      check(irqLine5, 0);
    end
    rd(`ADDR_EVENT_STATUS);
    check(r, 32'h2);
    wr(`ADDR_CONTROL, 32'h63);
    rd(`ADDR_CONTROL);
    check(r, 32'h93);
    wr(`ADDR_CONTROL, 32'h93);
    repeat (12) wr(`ADDR_CONTROL, 32'h13);
    rd(`ADDR_CONTROL);
    check(r, 32'h13);
    check(hrCnt, 0);
    // reset mode
    power_on;
    wr(`ADDR_CONTROL, 32'h20);
    t0 = hrCnt;
    wr(`ADDR_CONTROL, 32'h30);
    wait_out(1, 30);
    check(ok, 1);
    repeat (45) @(posedge clk_sys);
    check(hrCnt - t0, `HARD_RESET_CYCLES);
    rd(`ADDR_CONTROL);
    check(r, 32'hb0);
    rd(`ADDR_RESET_STATUS);
    check(r, 32'h1);
    wr(`ADDR_RESET_STATUS, 32'h1);
    rd(`ADDR_RESET_STATUS);
    check(r, 32'h0);
    wr(`ADDR_CONTROL, 32'h80);
    rd(`ADDR_CONTROL);
    check(r, 32'h30);
    // interrupt mode, routing and masking
    power_on;
    wr(`ADDR_IRQ_CONFIG, 32'h1);
    wr(`ADDR_EVENT_MASK, 32'h1);
    wr(`ADDR_CONTROL, 32'h41);
    t0 = hrCnt;
    wr(`ADDR_CONTROL, 32'h51);
    wait_out(0, 40);
    check(ok, 1);
    check(hrCnt, t0);
    wr(`ADDR_IRQ_CONFIG, 32'h2);
    repeat (2) @(posedge clk_sys);
    check(irqLine5, 0);
    wr(`ADDR_IRQ_CONFIG, 32'h1);
    repeat (2) @(posedge clk_sys);
    check(irqLine5, 1);
    wr(`ADDR_EVENT_MASK, 32'h0);
    repeat (2) @(posedge clk_sys);
    check(irqLine5, 0);
    wr(`ADDR_EVENT_MASK, 32'h1);
    wr(`ADDR_EVENT_STATUS, 32'h1);
    repeat (2) @(posedge clk_sys);
    check(irqLine5, 0);
    rd(`ADDR_EVENT_STATUS);
    check(r, 32'h2);
    // dual stage: retrigger resumes, then silence ends in reset
    power_on;
    wr(`ADDR_IRQ_CONFIG, 32'h1);
    wr(`ADDR_EVENT_MASK, 32'h1);
    wr(`ADDR_CONTROL, 32'h61);
    t0 = hrCnt;
    wr(`ADDR_CONTROL, 32'h71);
    wait_out(0, 40);
    check(ok, 1);
    repeat (8) wr(`ADDR_CONTROL, 32'h71);
    check(hrCnt, t0);
    wait_out(1, 60);
    check(ok, 1);
    repeat (45) @(posedge clk_sys);
    check(hrCnt - t0, `HARD_RESET_CYCLES);
    rd(`ADDR_RESET_STATUS);
    check(r, 32'h1);
    wrap_up;
  end
endmodule // tb_board_watchdog_timer
